// ### rtl/vpic_pkg.sv
// Constants shared by the VMEbus interrupt controller block.
// Assumes a 32-bit register port with byte addresses.
package vpic_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_VME_INTERRUPT_CONTROL_REG = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_OUTEN = 8'h0c;
  localparam logic [7:0] OFS_MAP_LO = 8'h10;
  localparam logic [7:0] OFS_MAP_HI = 8'h14;
  localparam logic [7:0] OFS_HVEC = 8'h18;
  localparam logic [7:0] OFS_HSTAT = 8'h1c;
  localparam logic [2:0] OFS_IACK_PAGE = 3'h1;

  // ----------------------------------------------------------------
  // Interrupt control register fields
  // ----------------------------------------------------------------
  localparam int VEC_LSB = 0;
  localparam int LVL_LSB = 8;
  localparam int PEND_BIT = 11;
  localparam int ACKEN_BIT = 12;
  localparam logic [2:0] LVL_NONE = 3'h0;

  // ----------------------------------------------------------------
  // Host read widths
  // ----------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 25;
  localparam int NUM_LINES = 4;
  localparam int MAP_LO_SRC = 16;
  localparam int SRC_ACK = 12;
  localparam logic [24:0] SRC_EDGE_MASK = 25'h1fffe00;
  localparam logic [24:0] RST_ZERO = 25'h0000000;

  typedef enum logic [1:0] {
    VPIC_IR_IDLE = 2'b00,
    VPIC_IR_REQ = 2'b01,
    VPIC_IR_ANSWER = 2'b10
  } vpic_ir_state_t;

  typedef enum logic {
    VPIC_H_IDLE = 1'b0,
    VPIC_H_RUN = 1'b1
  } vpic_h_state_t;

endpackage

// ### rtl/vpic_irq_source.sv
// One local interrupt source: enable gating and a status bit.
// Assumes the raw input is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module vpic_irq_source #(
  parameter bit EDGE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Source and controls
  input wire logic raw,
  input wire logic enable,
  input wire logic clear,
  // State
  output logic status
);

  logic raw_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= raw;
    end
  end

  // Edge sources latch; a new edge beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 1'b0;
    end else if (EDGE) begin
      if (enable && raw && !raw_q) begin
        status <= 1'b1;
      end else if (clear) begin
        status <= 1'b0;
      end
    end else begin
      status <= enable & raw;
    end
  end

endmodule
`default_nettype wire

// ### rtl/vpic_iack_handler.sv
// Interrupt handler sequencer: runs one acknowledge cycle per request.
// Assumes the VMEbus master answers with done and the vector.
`timescale 1ns/1ps
`default_nettype none
module vpic_iack_handler #(
  parameter int VEC_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the register port
  input wire logic start,
  input wire logic [2:0] start_lvl,
  input wire logic [1:0] start_size,
  input wire logic done_clr,
  // VMEbus master side
  output logic iack_req,
  output logic [2:0] iack_lvl,
  output logic [1:0] iack_size,
  input wire logic iack_done_in,
  input wire logic [VEC_W-1:0] iack_vec_in,
  // Result
  output logic busy,
  output logic done,
  output logic [VEC_W-1:0] vector
);

  vpic_pkg::vpic_h_state_t state;

  // Only a 32-bit vector path is served
  if (VEC_W != 32) begin : g_width_check
    $error("vpic_iack_handler: VEC_W must be 32");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= vpic_pkg::VPIC_H_IDLE;
      iack_req <= 1'b0;
      iack_lvl <= 3'h0;
      iack_size <= 2'h0;
    end else begin
      unique case (state)
        vpic_pkg::VPIC_H_IDLE: begin
          if (start) begin
            state <= vpic_pkg::VPIC_H_RUN;
            iack_req <= 1'b1;
            iack_lvl <= start_lvl;
            iack_size <= start_size;
          end
        end
        vpic_pkg::VPIC_H_RUN: begin
          if (iack_done_in) begin
            state <= vpic_pkg::VPIC_H_IDLE;
            iack_req <= 1'b0;
          end
        end
      endcase
    end
  end

  assign busy = (state == vpic_pkg::VPIC_H_RUN);

  // Vector and done flag; completion beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      vector <= '0;
    end else if (busy && iack_done_in) begin
      done <= 1'b1;
      vector <= iack_vec_in;
    end else if (done_clr) begin
      done <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### rtl/vpic_top.sv
// VMEbus interrupter, local interrupter and interrupt handler.
// Assumes all inputs are synchronous to ref_clk.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vpic_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_size,
  output logic [31:0] reg_rdata,
  // Interrupt sources
  input wire logic [7:1] vme_irq_in_n,
  input wire logic ac_fail_input_n,
  input wire logic system_fail_input,
  input wire logic vme_err_event,
  input wire logic [1:0] dma_event,
  input wire logic bcast_event,
  input wire logic clock_event,
  input wire logic counter_event,
  input wire logic pci_err_event,
  input wire logic [3:0] mailbox_event,
  input wire logic [3:0] locmon_event,
  // VMEbus interrupter
  output logic [7:1] irq_out_oe,
  input wire logic vme_iack_in,
  input wire logic [2:0] vme_iack_lvl_in,
  output logic vme_iack_out,
  output logic [7:0] vme_vec_out,
  output logic vme_vec_oe,
  output logic vme_dtack_oe,
  // VMEbus interrupt handler
  output logic iack_req,
  output logic [2:0] iack_lvl,
  output logic [1:0] iack_size,
  input wire logic iack_done_in,
  input wire logic [31:0] iack_vec_in,
  // Local interrupt lines, open drain
  output logic [3:0] local_int_oe,
  output logic local_int_out_a_n,
  output logic local_int_out_b_n,
  output logic local_int_out_c_n,
  output logic local_int_out_d_n,
  output logic int_any
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wr_vme_interrupt_control_reg;
  logic wr_status;
  logic rd_iack;
  logic rd_hstat;
  logic [2:0] rd_iack_lvl;

  assign wr_vme_interrupt_control_reg = reg_wr && (reg_addr == vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG);
  assign wr_status = reg_wr && (reg_addr == vpic_pkg::OFS_STATUS);
  assign rd_hstat = reg_rd && (reg_addr == vpic_pkg::OFS_HSTAT);
  assign rd_iack = reg_rd && (reg_addr[7:5] == vpic_pkg::OFS_IACK_PAGE)
                   && (reg_addr[4:2] != 3'h7) && (reg_addr[1:0] == 2'h0);
  assign rd_iack_lvl = reg_addr[4:2] + 3'h1;

  // ----------------------------------------------------------------
  // VMEbus interrupter
  // ----------------------------------------------------------------
  vpic_pkg::vpic_ir_state_t ir_state;
  logic [7:0] int_vector;
  logic [2:0] req_level;
  logic request_pending_flag;
  logic ack_event_en;
  logic ack_event;
  logic claim;
  logic [2:0] wr_level;

  assign wr_level = reg_wdata[vpic_pkg::LVL_LSB +: 3];
  assign claim = (ir_state == vpic_pkg::VPIC_IR_ANSWER)
                 || ((ir_state == vpic_pkg::VPIC_IR_REQ) && vme_iack_in
                     && (vme_iack_lvl_in == req_level));

  // Vector and acknowledge enable are held while a request is out
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_vector <= 8'h00;
      ack_event_en <= 1'b0;
    end else if (wr_vme_interrupt_control_reg && !request_pending_flag) begin
      int_vector <= reg_wdata[vpic_pkg::VEC_LSB +: 8];
      ack_event_en <= reg_wdata[vpic_pkg::ACKEN_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ir_state <= vpic_pkg::VPIC_IR_IDLE;
      req_level <= vpic_pkg::LVL_NONE;
      request_pending_flag <= 1'b0;
      irq_out_oe <= 7'h00;
      ack_event <= 1'b0;
      vme_vec_out <= 8'h00;
      vme_vec_oe <= 1'b0;
      vme_dtack_oe <= 1'b0;
    end else begin
      ack_event <= 1'b0;
      unique case (ir_state)
        vpic_pkg::VPIC_IR_IDLE: begin
          // Only the interrupter drives the request lines
          if (wr_vme_interrupt_control_reg && (wr_level != vpic_pkg::LVL_NONE)) begin
            ir_state <= vpic_pkg::VPIC_IR_REQ;
            req_level <= wr_level;
            irq_out_oe <= 7'(7'h01 << (wr_level - 3'h1));
            request_pending_flag <= 1'b1;
          end
        end
        vpic_pkg::VPIC_IR_REQ: begin
          // Further level writes are ignored here
          if (claim) begin
            ir_state <= vpic_pkg::VPIC_IR_ANSWER;
            irq_out_oe <= 7'h00;
            request_pending_flag <= 1'b0;
            ack_event <= ack_event_en;
            vme_vec_out <= int_vector;
            vme_vec_oe <= 1'b1;
            vme_dtack_oe <= 1'b1;
          end
        end
        vpic_pkg::VPIC_IR_ANSWER: begin
          if (!vme_iack_in) begin
            ir_state <= vpic_pkg::VPIC_IR_IDLE;
            req_level <= vpic_pkg::LVL_NONE;
            vme_vec_oe <= 1'b0;
            vme_dtack_oe <= 1'b0;
          end
        end
        default: begin
          ir_state <= vpic_pkg::VPIC_IR_IDLE;
        end
      endcase
    end
  end

  // Acknowledges not meant for this board pass down the chain
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vme_iack_out <= 1'b0;
    end else begin
      vme_iack_out <= vme_iack_in && !claim;
    end
  end

  // ----------------------------------------------------------------
  // Local interrupter controls
  // ----------------------------------------------------------------
  logic [24:0] src_enable;
  logic [24:0] src_outen;
  logic [31:0] map_lo;
  logic [17:0] map_hi;
  logic [49:0] map_all;
  logic [24:0] src_raw;
  logic [24:0] src_status;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_enable <= vpic_pkg::RST_ZERO;
    end else if (reg_wr && (reg_addr == vpic_pkg::OFS_ENABLE)) begin
      src_enable <= reg_wdata[24:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_outen <= vpic_pkg::RST_ZERO;
    end else if (reg_wr && (reg_addr == vpic_pkg::OFS_OUTEN)) begin
      src_outen <= reg_wdata[24:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      map_lo <= 32'h00000000;
      map_hi <= 18'h00000;
    end else if (reg_wr && (reg_addr == vpic_pkg::OFS_MAP_LO)) begin
      map_lo <= reg_wdata;
    end else if (reg_wr && (reg_addr == vpic_pkg::OFS_MAP_HI)) begin
      map_hi <= reg_wdata[17:0];
    end
  end

  assign map_all = {map_hi, map_lo};

  // Source order, bit 24 downward
  assign src_raw = {locmon_event, mailbox_event, pci_err_event,
                    counter_event, clock_event, bcast_event, ack_event,
                    dma_event, vme_err_event, system_fail_input,
                    ~ac_fail_input_n, ~vme_irq_in_n};

  // ----------------------------------------------------------------
  // Source cells
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < vpic_pkg::NUM_SRC; gi++) begin : g_src
      vpic_irq_source #(
        .EDGE(vpic_pkg::SRC_EDGE_MASK[gi])
      ) u_src (
        .clk(ref_clk),
        .rst_n(resetn),
        .raw(src_raw[gi]),
        .enable(src_enable[gi]),
        .clear(wr_status && reg_wdata[gi]),
        .status(src_status[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Line routing
  // ----------------------------------------------------------------
  logic [3:0] line_act;

  always_comb begin
    line_act = 4'h0;
    for (int i = 0; i < vpic_pkg::NUM_SRC; i++) begin
      if (src_enable[i] && src_status[i] && src_outen[i]) begin
        line_act[map_all[2*i +: 2]] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      local_int_oe <= 4'h0;
      local_int_out_a_n <= 1'b1;
      local_int_out_b_n <= 1'b1;
      local_int_out_c_n <= 1'b1;
      local_int_out_d_n <= 1'b1;
      int_any <= 1'b0;
    end else begin
      local_int_oe <= line_act;
      local_int_out_a_n <= ~line_act[0];
      local_int_out_b_n <= ~line_act[1];
      local_int_out_c_n <= ~line_act[2];
      local_int_out_d_n <= ~line_act[3];
      int_any <= |line_act;
    end
  end

  // ----------------------------------------------------------------
  // VMEbus interrupt handler
  // ----------------------------------------------------------------
  logic h_busy;
  logic h_done;
  logic [31:0] h_vector;

  vpic_iack_handler #(
    .VEC_W(32)
  ) u_handler (
    .clk(ref_clk),
    .rst_n(resetn),
    .start(rd_iack),
    .start_lvl(rd_iack_lvl),
    .start_size(reg_size),
    .done_clr(rd_hstat),
    .iack_req(iack_req),
    .iack_lvl(iack_lvl),
    .iack_size(iack_size),
    .iack_done_in(iack_done_in),
    .iack_vec_in(iack_vec_in),
    .busy(h_busy),
    .done(h_done),
    .vector(h_vector)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (reg_addr)
      vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG: begin
        next_rdata[vpic_pkg::VEC_LSB +: 8] = int_vector;
        next_rdata[vpic_pkg::LVL_LSB +: 3] = req_level;
        next_rdata[vpic_pkg::PEND_BIT] = request_pending_flag;
        next_rdata[vpic_pkg::ACKEN_BIT] = ack_event_en;
      end
      vpic_pkg::OFS_ENABLE: begin
        next_rdata[24:0] = src_enable;
      end
      vpic_pkg::OFS_STATUS: begin
        next_rdata[24:0] = src_status;
      end
      vpic_pkg::OFS_OUTEN: begin
        next_rdata[24:0] = src_outen;
      end
      vpic_pkg::OFS_MAP_LO: begin
        next_rdata = map_lo;
      end
      vpic_pkg::OFS_MAP_HI: begin
        next_rdata[17:0] = map_hi;
      end
      vpic_pkg::OFS_HVEC: begin
        next_rdata = h_vector;
      end
      vpic_pkg::OFS_HSTAT: begin
        next_rdata[1:0] = {h_done, h_busy};
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ### tb/vpic_monitor.sv
// Concurrent checks on the ports of the interrupt controller top.
// Assumes every port is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module vpic_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_size,
  input wire logic [31:0] reg_rdata,
  // VMEbus interrupter
  input wire logic [7:1] irq_out_oe,
  input wire logic vme_iack_in,
  input wire logic [2:0] vme_iack_lvl_in,
  input wire logic vme_iack_out,
  input wire logic [7:0] vme_vec_out,
  input wire logic vme_vec_oe,
  input wire logic vme_dtack_oe,
  // VMEbus handler
  input wire logic iack_req,
  input wire logic [2:0] iack_lvl,
  input wire logic [1:0] iack_size,
  input wire logic iack_done_in,
  // Local lines
  input wire logic [3:0] local_int_oe,
  input wire logic local_int_out_a_n,
  input wire logic local_int_out_b_n,
  input wire logic local_int_out_c_n,
  input wire logic local_int_out_d_n
);
  logic [7:0] vec_s;
  logic idle;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  assign idle = irq_out_oe == 7'h0 && !vme_vec_oe;

  // Vector accepted by a write in the idle state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) vec_s <= 8'h0;
    else if (reg_wr && reg_addr == vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG && idle)
      vec_s <= reg_wdata[7:0];
  end

  lines_level_a: assert property (
    {local_int_out_d_n, local_int_out_c_n, local_int_out_b_n,
     local_int_out_a_n} == ~local_int_oe) else $error("line level");
  one_request_a: assert property (
    $onehot0(irq_out_oe)) else $error("two requests");
  req_start_a: assert property (
    reg_wr && reg_addr == vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG && idle &&
    reg_wdata[10:8] != 3'h0 |=>
    irq_out_oe == (7'h01 << ($past(reg_wdata[10:8]) - 3'h1)))
    else $error("request line");
  req_hold_a: assert property (
    irq_out_oe != 7'h0 && !vme_iack_in |=> $stable(irq_out_oe))
    else $error("request dropped");
  claim_release_a: assert property (
    vme_iack_in && vme_iack_lvl_in != 3'h0 && irq_out_oe[vme_iack_lvl_in]
    |=> irq_out_oe == 7'h0 && vme_vec_oe && vme_dtack_oe)
    else $error("no release");
  vector_out_a: assert property (
    vme_vec_oe |-> vme_vec_out == vec_s) else $error("vector");
  vec_free_a: assert property (
    vme_vec_oe && !vme_iack_in |=> !vme_vec_oe && !vme_dtack_oe)
    else $error("vector held");
  daisy_pass_a: assert property (
    vme_iack_in && vme_iack_lvl_in != 3'h0 && !vme_vec_oe &&
    !irq_out_oe[vme_iack_lvl_in] |=> vme_iack_out) else $error("daisy");
  no_vme_route_a: assert property (
    local_int_oe != 4'h0 && irq_out_oe == 7'h0 && !reg_wr |=>
    irq_out_oe == 7'h0) else $error("local on vme");
  hnd_start_a: assert property (
    reg_rd && reg_addr[7:5] == vpic_pkg::OFS_IACK_PAGE &&
    reg_addr[4:2] != 3'h7 && reg_addr[1:0] == 2'h0 && !iack_req |=>
    iack_req && iack_lvl == $past(reg_addr[4:2]) + 3'h1 &&
    iack_size == $past(reg_size)) else $error("handler start");
  hnd_hold_a: assert property (
    iack_req && !iack_done_in |=> iack_req && $stable(iack_lvl) &&
    $stable(iack_size)) else $error("handler hold");
  hnd_end_a: assert property (
    iack_req && iack_done_in |=> !iack_req) else $error("handler end");
  ack_rdata_a: assert property (
    reg_rd && reg_addr[7:5] == vpic_pkg::OFS_IACK_PAGE |=>
    reg_rdata == 32'h0) else $error("ack read data");
endmodule
bind vpic_top vpic_monitor u_vpic_monitor (
  .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_size(reg_size), .reg_rdata(reg_rdata), .irq_out_oe(irq_out_oe),
  .vme_iack_in(vme_iack_in), .vme_iack_lvl_in(vme_iack_lvl_in),
  .vme_iack_out(vme_iack_out), .vme_vec_out(vme_vec_out),
  .vme_vec_oe(vme_vec_oe), .vme_dtack_oe(vme_dtack_oe),
  .iack_req(iack_req), .iack_lvl(iack_lvl), .iack_size(iack_size),
  .iack_done_in(iack_done_in), .local_int_oe(local_int_oe),
  .local_int_out_a_n(local_int_out_a_n),
  .local_int_out_b_n(local_int_out_b_n),
  .local_int_out_c_n(local_int_out_c_n),
  .local_int_out_d_n(local_int_out_d_n));
`default_nettype wire

// ### tb/vpic_partner.sv
// Far-side model: VMEbus acknowledge source and VMEbus master.
// Assumes design outputs change just after rising ref_clk edges.
`timescale 1ns/1ps
`default_nettype none
module vpic_partner (
  // Clock
  input wire logic ref_clk,
  // Interrupter side
  input wire logic [7:1] irq_out_oe,
  input wire logic vme_dtack_oe,
  output logic vme_iack_in,
  output logic [2:0] vme_iack_lvl_in,
  // Handler side
  input wire logic iack_req,
  input wire logic [2:0] iack_lvl,
  input wire logic [1:0] iack_size,
  output logic iack_done_in,
  output logic [31:0] iack_vec_in
);
  int lv, k, w;

  // Foreign-level acknowledge first, then our own until answered
  initial begin
    vme_iack_in = 1'b0;
    vme_iack_lvl_in = 3'h0;
    forever begin
      @(posedge ref_clk);
      vme_iack_lvl_in <= ~vme_iack_lvl_in;
      if (irq_out_oe != 7'h0) begin
        for (k = 1; k < 8; k++) if (irq_out_oe[k]) lv = k;
        repeat (4) @(posedge ref_clk);
        vme_iack_in <= 1'b1;
        vme_iack_lvl_in <= 3'(lv % 7 + 1);
        repeat (2) @(posedge ref_clk);
        vme_iack_in <= 1'b0;
        @(posedge ref_clk);
        vme_iack_in <= 1'b1;
        vme_iack_lvl_in <= 3'(lv);
        for (k = 0; k < 20 && !vme_dtack_oe; k++) @(posedge ref_clk);
        vme_iack_in <= 1'b0;
      end
    end
  end

  // Slower answer for higher levels; data valid only with done
  initial begin
    iack_done_in = 1'b0;
    iack_vec_in = 32'h0;
    w = 0;
    forever begin
      @(posedge ref_clk);
      iack_done_in <= 1'b0;
      if (iack_req && !iack_done_in) w++;
      if (w > 2 + 2 * iack_lvl) begin
        w = 0;
        iack_done_in <= 1'b1;
        iack_vec_in <= {16'hc0de, 6'h0, iack_size, 8'(iack_lvl)};
      end else begin
        iack_vec_in <= ~iack_vec_in;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/vpic_top_tb.sv
// Self-checking bench for the interrupt controller top.
// Assumes the partner model answers both VMEbus sides.
`timescale 1ns/1ps
`default_nettype none
module vpic_top_tb;
  logic ref_clk, resetn, reg_wr, reg_rd, rd_d, int_any;
  logic [7:0] reg_addr, vme_vec_out, v;
  logic [31:0] reg_wdata, reg_rdata, iack_vec_in, en, oe, e, m;
  logic [1:0] reg_size, iack_size, sz;
  logic [24:0] src;
  logic [7:1] irq_out_oe;
  logic vme_iack_in, vme_iack_out, vme_vec_oe, vme_dtack_oe;
  logic iack_req, iack_done_in;
  logic [2:0] vme_iack_lvl_in, iack_lvl;
  logic [3:0] local_int_oe, lines, li;
  logic [49:0] map;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int errors, checks, cyc, n, seed;

  vpic_top u_vpic_top (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_size(reg_size), .reg_rdata(reg_rdata),
    .vme_irq_in_n(~src[6:0]), .ac_fail_input_n(~src[7]),
    .system_fail_input(src[8]), .vme_err_event(src[9]),
    .dma_event(src[11:10]), .bcast_event(src[13]),
    .clock_event(src[14]), .counter_event(src[15]),
    .pci_err_event(src[16]), .mailbox_event(src[20:17]),
    .locmon_event(src[24:21]), .irq_out_oe(irq_out_oe),
    .vme_iack_in(vme_iack_in), .vme_iack_lvl_in(vme_iack_lvl_in),
    .vme_iack_out(vme_iack_out), .vme_vec_out(vme_vec_out),
    .vme_vec_oe(vme_vec_oe), .vme_dtack_oe(vme_dtack_oe),
    .iack_req(iack_req), .iack_lvl(iack_lvl), .iack_size(iack_size),
    .iack_done_in(iack_done_in), .iack_vec_in(iack_vec_in),
    .local_int_oe(local_int_oe), .local_int_out_a_n(lines[0]),
    .local_int_out_b_n(lines[1]), .local_int_out_c_n(lines[2]),
    .local_int_out_d_n(lines[3]), .int_any(int_any));

  vpic_partner u_vpic_partner (.ref_clk(ref_clk), .irq_out_oe(irq_out_oe),
    .vme_dtack_oe(vme_dtack_oe), .vme_iack_in(vme_iack_in),
    .vme_iack_lvl_in(vme_iack_lvl_in), .iack_req(iack_req),
    .iack_lvl(iack_lvl), .iack_size(iack_size),
    .iack_done_in(iack_done_in), .iack_vec_in(iack_vec_in));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic void cmp(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endfunction

  task automatic end_sim;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    @(negedge ref_clk);
    cmp(got, want);
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want,
      input logic [31:0] msk, input logic [1:0] s = vpic_pkg::SIZE_WORD);
    exp_q.push_back(want);
    msk_q.push_back(msk);
    reg_addr <= a;
    reg_size <= s;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_idle;
    for (int k = 0; k < 60 && (irq_out_oe != 7'h0 || vme_vec_oe || iack_req);
         k++) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Read data watcher: oldest note against the answer cycle
  // ----------------------------------------------------------------
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      cmp(reg_rdata & m, e & m);
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 6000) begin
      errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h89c5;
    {reg_addr, reg_wdata, reg_wr, reg_rd, reg_size, src} = '0;
    resetn = 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    wr(8'hfc, 32'hffffffff);
    for (n = 0; n < 8; n++) rd(8'(4 * n), 32'h0, '1);
    rd(8'hfc, 32'h0, '1);
    $display("test reset done");
    wr(vpic_pkg::OFS_ENABLE, 32'h1ffffff);
    for (n = 1; n < 8; n++) begin
      v = 8'($random(seed));
      wr(vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG, {19'h0, n[0], 1'b0, 3'(n), v});
      wr(vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG, {19'h0, 1'b1, 1'b0, 3'(8 - n), ~v});
      rd(vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG, {19'h0, n[0], 1'b1, 3'(n), v}, '1);
      chk({24'h0, irq_out_oe, 1'b0}, 32'h1 << n);
      wait_idle();
      rd(vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG, {19'h0, n[0], 12'(v)}, 32'hfffff8ff);
      rd(vpic_pkg::OFS_STATUS, {19'h0, n[0], 12'h0}, '1);
      wr(vpic_pkg::OFS_STATUS, 32'h1000);
      rd(vpic_pkg::OFS_STATUS, 32'h0, '1);
    end
    $display("test interrupter done");
    en = $random(seed);
    oe = $random(seed);
    map[31:0] = $random(seed);
    map[49:32] = 18'($random(seed));
    wr(vpic_pkg::OFS_ENABLE, en);
    wr(vpic_pkg::OFS_OUTEN, oe);
    wr(vpic_pkg::OFS_MAP_LO, map[31:0]);
    wr(vpic_pkg::OFS_MAP_HI, {14'h0, map[49:32]});
    for (n = 0; n < 25; n++) if (n != 12) begin
      src[n] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      li = (en[n] && oe[n]) ? 4'h1 << map[2 * n +: 2] : 4'h0;
      chk({28'h0, lines}, {28'h0, ~li});
      chk({31'h0, int_any}, {31'h0, |li});
      chk({25'h0, irq_out_oe}, 32'h0);
      rd(vpic_pkg::OFS_STATUS, 32'(en[n]) << n, '1);
      src[n] <= 1'b0;
      wr(vpic_pkg::OFS_STATUS, 32'h1 << n);
      rd(vpic_pkg::OFS_STATUS, 32'h0, '1);
      chk({28'h0, lines}, 32'hf);
    end
    $display("test local lines done");
    for (n = 1; n < 8; n++) begin
      sz = 2'(n % 3);
      rd(8'h20 + 8'(4 * (n - 1)), 32'h0, '1, sz);
      rd(8'h20, 32'h0, '1);
      wait_idle();
      rd(vpic_pkg::OFS_HSTAT, 32'h2, '1);
      rd(vpic_pkg::OFS_HVEC, {16'hc0de, 6'h0, sz, 8'(n)}, '1);
      rd(vpic_pkg::OFS_HSTAT, 32'h0, '1);
    end
    $display("test handler done");
    wr(vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG, 32'h1533);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    chk({25'h0, irq_out_oe}, 32'h0);
    rd(vpic_pkg::OFS_VME_INTERRUPT_CONTROL_REG, 32'h0, '1);
    repeat (30) @(posedge ref_clk);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire
